/* design/vlsr_consts.svh */
// Purpose: Constants for the output ceiling, margin and slew-rate registers
// Assumes: Word-level command port from the bus engine, 10 MHz clock
// Notes:   Voltage words use an output-voltage exponent of -9
`ifndef VLSR_CONSTS_SVH
`define VLSR_CONSTS_SVH

// ==========================================================================
// Command codes
`define VLSR_CODE_CEILING   8'h24
`define VLSR_CODE_MARG_HI   8'h25
`define VLSR_CODE_MARG_LO   8'h26
`define VLSR_CODE_SLEW      8'h27

// ==========================================================================
// Slew-rate word fields
`define VLSR_EXP_HI         15
`define VLSR_EXP_LO         11
`define VLSR_MAN_HI         10
`define VLSR_MAN_LO         0
`define VLSR_EXP_RESET      5'h1c
`define VLSR_MAN_MIN        11'h002
`define VLSR_MAN_MAX        11'h0fe

// ==========================================================================
// Margin select codes of the operation word
`define VLSR_MARGIN_LOW     2'h1
`define VLSR_MARGIN_HIGH    2'h2

// ==========================================================================
// Slew timing: per cycle add man * CLK_NS * 32, step one LSB per DEN
`define VLSR_CLK_NS         100
`define VLSR_SLEW_SCALE     32
`define VLSR_SLEW_DEN       20'hf4240
`define VLSR_ZERO16         16'h0000

`endif

/* design/vlsr_pkg.sv */
// Purpose: Types for the output ceiling, margin and slew-rate registers
// Assumes: Single 10 MHz clock domain
// Notes:   Whole block state is one packed struct
package vlsr_pkg;

    typedef enum logic [0:0] {
        VLSR_LOAD,
        VLSR_RUN
    } vlsr_phase_type;

    typedef struct packed {
        vlsr_phase_type phase;
        logic [15:0]    ceiling;
        logic [15:0]    marg_hi;
        logic [15:0]    marg_lo;
        logic [15:0]    slew;
        logic [15:0]    target;
        logic [19:0]    acc;
        logic           over;
        logic [15:0]    rdata;
        logic           ack;
        logic           nack;
        logic           warn;
        logic           cml;
        logic           alert;
    } vlsr_state_type;

endpackage

/* design/vlsr_regs.sv */
// Purpose: Ceiling, margin and slew-rate command registers with target ramp
// Assumes: Command port and control inputs come from logic on i_clk
// Notes:   Whole block state is one packed struct, registered every rising edge
`timescale 1ns/10ps
`default_nettype none
`include "vlsr_consts.svh"

module vlsr_regs (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Word command port
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [7:0]  i_cmd_code,
    input  wire logic [15:0] i_cmd_wdata,
    output logic             o_cmd_ack,
    output logic             o_cmd_nack,
    output logic [15:0]      o_cmd_rdata,
    // Backup values
    input  wire logic        i_nvm_valid,
    input  wire logic        i_ceiling_from_pin,
    input  wire logic [15:0] i_pin_ceiling,
    input  wire logic [15:0] i_nvm_ceiling,
    input  wire logic [15:0] i_nvm_marg_hi,
    input  wire logic [15:0] i_nvm_marg_lo,
    input  wire logic [10:0] i_nvm_slew_man,
    // Setpoint sources
    input  wire logic        i_conv_en,
    input  wire logic        i_on_off_ramp,
    input  wire logic [1:0]  i_margin_sel,
    input  wire logic [15:0] i_vout_command,
    input  wire logic [15:0] i_vout_trim,
    input  wire logic [15:0] i_dac_limit,
    // Target and reporting
    output logic [15:0]      o_target,
    output logic             o_ready,
    output logic             o_set_status_byte_nota,
    output logic             o_set_status_word_vout,
    output logic             o_set_status_vout_warn,
    output logic             o_set_status_cml_data,
    output logic             o_alert,
    input  wire logic        i_alert_clear
);

    vlsr_pkg::vlsr_state_type st_r;
    vlsr_pkg::vlsr_state_type st_nxt;

    // ======================================================================
    // Helpers
    function automatic logic [17:0] add_trim(input logic [15:0] v, input logic [15:0] t);
        add_trim = {2'b00, v} + {{2{t[15]}}, t};
    endfunction

    function automatic logic fits(input logic [17:0] s, input logic [15:0] ceil);
        fits = !s[17] && (s <= {2'b00, ceil});
    endfunction

    function automatic logic [19:0] slew_step(input logic [15:0] w);
        slew_step = 20'(w[`VLSR_MAN_HI:`VLSR_MAN_LO] * (`VLSR_CLK_NS * `VLSR_SLEW_SCALE));
    endfunction

    // ======================================================================
    // Goal selection and clamp
    logic [17:0] sum;
    logic [15:0] goal;
    logic        over_now;
    logic        dac_lim;
    logic        cmd_wr;
    logic        cmd_rd;
    logic [17:0] wsum;
    logic        slew_ok;
    logic [20:0] acc_sum;

    always_comb begin
        unique case (i_margin_sel)
            `VLSR_MARGIN_HIGH: sum = add_trim(st_r.marg_hi, i_vout_trim);
            `VLSR_MARGIN_LOW:  sum = add_trim(st_r.marg_lo, i_vout_trim);
            default:           sum = add_trim(i_vout_command, i_vout_trim);
        endcase
        dac_lim  = (i_dac_limit <= st_r.ceiling) && !sum[17]
                   && (sum > {2'b00, i_dac_limit});
        over_now = !sum[17] && (sum > {2'b00, st_r.ceiling}) && !dac_lim;
        if (sum[17])
            goal = `VLSR_ZERO16;
        else if (dac_lim)
            goal = i_dac_limit;
        else if (over_now)
            goal = st_r.ceiling;
        else
            goal = sum[15:0];
    end

    // ======================================================================
    // Command decode
    always_comb begin
        cmd_wr  = i_cmd_valid && i_cmd_write && (st_r.phase == vlsr_pkg::VLSR_RUN);
        cmd_rd  = i_cmd_valid && !i_cmd_write && (st_r.phase == vlsr_pkg::VLSR_RUN);
        wsum    = add_trim(i_cmd_wdata, i_vout_trim);
        slew_ok = (i_cmd_wdata[`VLSR_EXP_HI:`VLSR_EXP_LO] == `VLSR_EXP_RESET)
                  && (i_cmd_wdata[`VLSR_MAN_HI:`VLSR_MAN_LO] >= `VLSR_MAN_MIN)
                  && (i_cmd_wdata[`VLSR_MAN_HI:`VLSR_MAN_LO] <= `VLSR_MAN_MAX);
        // Spare bit: accumulator plus step can pass the 20-bit range
        acc_sum = {1'b0, st_r.acc} + {1'b0, slew_step(st_r.slew)};
    end

    // ======================================================================
    // Next state
    always_comb begin
        st_nxt      = st_r;
        st_nxt.ack  = 1'b0;
        st_nxt.nack = 1'b0;
        st_nxt.warn = 1'b0;
        st_nxt.cml  = 1'b0;
        unique case (st_r.phase)
            vlsr_pkg::VLSR_LOAD: begin
                if (i_nvm_valid) begin
                    st_nxt.ceiling = i_ceiling_from_pin ? i_pin_ceiling
                                                        : i_nvm_ceiling;
                    st_nxt.marg_hi = i_nvm_marg_hi;
                    st_nxt.marg_lo = i_nvm_marg_lo;
                    st_nxt.slew    = {`VLSR_EXP_RESET, i_nvm_slew_man};
                    st_nxt.phase   = vlsr_pkg::VLSR_RUN;
                end
            end
            vlsr_pkg::VLSR_RUN: begin
                if (cmd_rd) begin
                    st_nxt.ack = 1'b1;
                    unique case (i_cmd_code)
                        `VLSR_CODE_CEILING: st_nxt.rdata = st_r.ceiling;
                        `VLSR_CODE_MARG_HI: st_nxt.rdata = st_r.marg_hi;
                        `VLSR_CODE_MARG_LO: st_nxt.rdata = st_r.marg_lo;
                        `VLSR_CODE_SLEW:    st_nxt.rdata = st_r.slew;
                        default: begin
                            st_nxt.ack   = 1'b0;
                            st_nxt.rdata = st_r.rdata;
                        end
                    endcase
                end
                if (cmd_wr) begin
                    unique case (i_cmd_code)
                        `VLSR_CODE_CEILING: begin
                            st_nxt.ceiling = i_cmd_wdata;
                            st_nxt.ack     = 1'b1;
                        end
                        `VLSR_CODE_MARG_HI, `VLSR_CODE_MARG_LO: begin
                            if (fits(wsum, st_r.ceiling)) begin
                                st_nxt.ack = 1'b1;
                                if (i_cmd_code == `VLSR_CODE_MARG_HI)
                                    st_nxt.marg_hi = i_cmd_wdata;
                                else
                                    st_nxt.marg_lo = i_cmd_wdata;
                            end else begin
                                st_nxt.nack = 1'b1;
                                st_nxt.cml  = 1'b1;
                            end
                        end
                        `VLSR_CODE_SLEW: begin
                            if (slew_ok) begin
                                st_nxt.slew = i_cmd_wdata;
                                st_nxt.ack  = 1'b1;
                            end else begin
                                st_nxt.nack = 1'b1;
                                st_nxt.cml  = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                end
                // Warning on the cycle the trimmed setpoint first exceeds the ceiling
                st_nxt.over = over_now && i_conv_en;
                st_nxt.warn = over_now && i_conv_en && !st_r.over;
                // Ramp toward the goal only during normal conversion
                if (!i_conv_en || i_on_off_ramp) begin
                    st_nxt.target = goal;
                    st_nxt.acc    = 20'h00000;
                end else if (st_r.target == goal) begin
                    st_nxt.acc = 20'h00000;
                end else if (acc_sum >= {1'b0, `VLSR_SLEW_DEN}) begin
                    st_nxt.acc    = 20'(acc_sum - {1'b0, `VLSR_SLEW_DEN});
                    st_nxt.target = (goal > st_r.target) ? st_r.target + 16'h0001
                                                         : st_r.target - 16'h0001;
                end else begin
                    st_nxt.acc = acc_sum[19:0];
                end
            end
        endcase
        // Set wins over clear
        if (st_nxt.warn || st_nxt.cml)
            st_nxt.alert = 1'b1;
        else if (i_alert_clear)
            st_nxt.alert = 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_r       <= '0;
            st_r.phase <= vlsr_pkg::VLSR_LOAD;
            st_r.slew  <= {`VLSR_EXP_RESET, 11'h000};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // Outputs
    assign o_cmd_ack              = st_r.ack;
    assign o_cmd_nack             = st_r.nack;
    assign o_cmd_rdata            = st_r.rdata;
    assign o_target               = st_r.target;
    assign o_ready                = (st_r.phase == vlsr_pkg::VLSR_RUN);
    assign o_set_status_byte_nota = st_r.warn;
    assign o_set_status_word_vout = st_r.warn;
    assign o_set_status_vout_warn = st_r.warn;
    assign o_set_status_cml_data  = st_r.cml;
    assign o_alert                = st_r.alert;

    // ======================================================================
    // Assertions
    sequence s_ceil_write;
        i_cmd_valid && i_cmd_write && o_ready && i_cmd_code == `VLSR_CODE_CEILING;
    endsequence

    sequence s_bad_margin;
        i_cmd_valid && i_cmd_write && o_ready
        && (i_cmd_code == `VLSR_CODE_MARG_HI || i_cmd_code == `VLSR_CODE_MARG_LO)
        && !fits(wsum, st_r.ceiling);
    endsequence

    a_ceiling_store: assert property (@(posedge i_clk) disable iff (i_reset)
        s_ceil_write |=> (st_r.ceiling == $past(i_cmd_wdata)) && o_cmd_ack)
        else $error("ceiling write not stored");

    a_warn_raise: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && i_conv_en && over_now && !st_r.over) |=> o_set_status_vout_warn)
        else $error("over-ceiling target gave no warning");

    a_warn_status: assert property (@(posedge i_clk) disable iff (i_reset)
        o_set_status_vout_warn |-> o_set_status_byte_nota && o_set_status_word_vout
        && $past(over_now))
        else $error("warning status bits out of step");

    a_warn_alert: assert property (@(posedge i_clk) disable iff (i_reset)
        o_set_status_vout_warn |-> o_alert)
        else $error("warning without alert");

    a_target_ceil: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && i_conv_en && !i_on_off_ramp && $stable(st_r.ceiling) && over_now)
        |=> o_target <= $past(st_r.ceiling) || o_target <= $past(o_target))
        else $error("target rose above ceiling");

    a_margin_refuse: assert property (@(posedge i_clk) disable iff (i_reset)
        s_bad_margin |=> o_cmd_nack && o_set_status_cml_data && o_alert
        && $stable(st_r.marg_hi) && $stable(st_r.marg_lo))
        else $error("bad margin write not refused");

    a_slew_step: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && i_conv_en && !i_on_off_ramp)
        |=> (o_target - $past(o_target) <= 16'h0001)
        || ($past(o_target) - o_target <= 16'h0001))
        else $error("target moved more than one step");

    a_onoff_direct: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && (!i_conv_en || i_on_off_ramp)) |=> o_target == $past(goal))
        else $error("turn-on target was ramped");

    a_load_first: assert property (@(posedge i_clk) disable iff (i_reset)
        !o_ready |=> !o_cmd_ack && !o_cmd_nack)
        else $error("command answered before load");

    a_slew_reset: assert property (@(posedge i_clk)
        $fell(i_reset) |-> st_r.slew[`VLSR_EXP_HI:`VLSR_EXP_LO] == `VLSR_EXP_RESET)
        else $error("slew exponent reset wrong");

    sequence s_good_margin;
        i_cmd_valid && i_cmd_write && o_ready && i_cmd_code == `VLSR_CODE_MARG_HI
        && fits(wsum, st_r.ceiling);
    endsequence

    sequence s_bad_slew;
        i_cmd_valid && i_cmd_write && o_ready && i_cmd_code == `VLSR_CODE_SLEW && !slew_ok;
    endsequence

    sequence s_ceil_read;
        i_cmd_valid && !i_cmd_write && o_ready && i_cmd_code == `VLSR_CODE_CEILING;
    endsequence

    a_margin_store: assert property (@(posedge i_clk) disable iff (i_reset)
        s_good_margin |=> o_cmd_ack && !o_cmd_nack && (st_r.marg_hi == $past(i_cmd_wdata)))
        else $error("valid margin-high write not stored");

    a_slew_refuse: assert property (@(posedge i_clk) disable iff (i_reset)
        s_bad_slew |=> o_cmd_nack && o_set_status_cml_data && $stable(st_r.slew))
        else $error("bad slew-rate write not refused");

    a_read_word: assert property (@(posedge i_clk) disable iff (i_reset)
        s_ceil_read |=> o_cmd_ack && (o_cmd_rdata == $past(st_r.ceiling)))
        else $error("ceiling read returned wrong word");

    a_margin_high: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && i_margin_sel == `VLSR_MARGIN_HIGH && !dac_lim
         && fits(add_trim(st_r.marg_hi, i_vout_trim), st_r.ceiling))
        |-> goal == st_r.marg_hi + i_vout_trim)
        else $error("margin-high goal is not margin plus trim");

    a_margin_low: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && i_margin_sel == `VLSR_MARGIN_LOW && !dac_lim
         && fits(add_trim(st_r.marg_lo, i_vout_trim), st_r.ceiling))
        |-> goal == st_r.marg_lo + i_vout_trim)
        else $error("margin-low goal is not margin plus trim");

    a_dac_exempt: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_ready && i_conv_en && dac_lim) |=> !o_set_status_vout_warn)
        else $error("warning raised for a DAC-limited target");

    a_alert_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_alert && !i_alert_clear) |=> o_alert)
        else $error("alert dropped without a clear");

    a_ready_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        o_ready |=> o_ready)
        else $error("ready dropped without reset");

endmodule

`default_nettype wire

/* sim/vlsr_host.sv */
// Purpose: Host model issuing word commands to the register block
// Assumes: One command at a time, answer one cycle after the take
// Notes:   Released lines show the inverse of the last word
`timescale 1ns/10ps
`default_nettype none

module vlsr_host (
    // Clock
    input  wire logic        i_clk,
    // Command port
    output logic             o_valid,
    output logic             o_write,
    output logic [7:0]       o_code,
    output logic [15:0]      o_wdata,
    input  wire logic        i_ack,
    input  wire logic        i_nack,
    input  wire logic [15:0] i_rdata
);
    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_code  = 8'h00;
        o_wdata = 16'h0000;
    end

    // Valid for one cycle, answer sampled mid-cycle after the take
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ack, output logic nack, output logic [15:0] rd);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_write <= wr;
        o_code  <= code;
        o_wdata <= data;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_code  <= ~code;
        o_wdata <= ~data;
        @(negedge i_clk);
        ack  = i_ack;
        nack = i_nack;
        rd   = i_rdata;
    endtask
endmodule
`default_nettype wire

/* sim/vout_limit_margin_slew_regs_tb_top.sv */
// Purpose: Self-checking bench for the ceiling, margin and slew registers
// Assumes: Voltage LSB 2^-9 V; ramp adds mantissa * 3200 per cycle
// Notes:   Ramp lengths are checked as lower bounds in cycles
`timescale 1ns/10ps
`default_nettype none

module vout_limit_margin_slew_regs_tb_top;
    logic        clk, rst, nvm_ok, psel, conv, onoff, clr, v, w, ack, nack;
    logic        rdy, nota, sw, sv, cml, alert, a, n;
    logic [1:0]  msel;
    logic [7:0]  code;
    logic [15:0] cmd, trim, dac, wd, rd, tgt, rdv;
    int          num_errors = 0, check_count = 0, cyc = 0, warns = 0, cmls = 0;
    logic [7:0]  bc [5] = '{8'h25, 8'h26, 8'h27, 8'h27, 8'h27};
    logic [15:0] bv [5] = '{16'h0301, 16'h0301, 16'he8fe, 16'he001, 16'he0ff};
    logic [15:0] kv [5] = '{16'h0200, 16'h0100, 16'he0fe, 16'he0fe, 16'he0fe};
    logic [15:0] gv [4] = '{16'h0300, 16'h0200, 16'h0100, 16'he0fe};

    vlsr_host i_host (.i_clk(clk), .o_valid(v), .o_write(w), .o_code(code), .o_wdata(wd),
        .i_ack(ack), .i_nack(nack), .i_rdata(rd));
    vlsr_regs i_dut (.i_clk(clk), .i_reset(rst), .i_cmd_valid(v), .i_cmd_write(w),
        .i_cmd_code(code), .i_cmd_wdata(wd), .o_cmd_ack(ack), .o_cmd_nack(nack),
        .o_cmd_rdata(rd), .i_nvm_valid(nvm_ok), .i_ceiling_from_pin(psel),
        .i_pin_ceiling(16'h0200), .i_nvm_ceiling(16'h0180), .i_nvm_marg_hi(16'h01c0),
        .i_nvm_marg_lo(16'h0100), .i_nvm_slew_man(11'h0fe), .i_conv_en(conv),
        .i_on_off_ramp(onoff), .i_margin_sel(msel), .i_vout_command(cmd),
        .i_vout_trim(trim), .i_dac_limit(dac), .o_target(tgt), .o_ready(rdy),
        .o_set_status_byte_nota(nota), .o_set_status_word_vout(sw),
        .o_set_status_vout_warn(sv), .o_set_status_cml_data(cml), .o_alert(alert),
        .i_alert_clear(clr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Pulse counters and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (nota & sw & sv)
            warns <= warns + 1;
        if (cml)
            cmls <= cmls + 1;
        if (cyc == 10000) begin
            num_errors++;
            stop_test();
        end
    end

    // ======================================================================
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ea, input logic en);
        i_host.xfer(1'b1, c, d, a, n, rdv);
        chk({15'h0, a}, {15'h0, ea});
        chk({15'h0, n}, {15'h0, en});
    endtask

    task automatic rdr(input logic [7:0] c, input logic [15:0] e);
        i_host.xfer(1'b0, c, 16'h0000, a, n, rdv);
        chk({15'h0, a}, 16'h0001);
        chk(rdv, e);
    endtask

    task automatic ramp(input logic [15:0] e, input int lo);
        int k;
        k = 0;
        while (tgt !== e && k < 5000) begin
            @(negedge clk);
            k++;
        end
        chk(tgt, e);
        chk(16'(k >= lo), 16'h0001);
    endtask

    task automatic clear();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(negedge clk);
        chk({15'h0, alert}, 16'h0000);
    endtask

    task automatic stop_test();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ======================================================================
    // Tests
    initial begin
        rst    = 1'b1;
        nvm_ok = 1'b0;
        psel   = 1'b1;
        conv   = 1'b1;
        onoff  = 1'b1;
        clr    = 1'b0;
        msel   = 2'h0;
        cmd    = 16'h0180;
        trim   = 16'h0000;
        dac    = 16'hffff;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wr(8'h24, 16'h0100, 1'b0, 1'b0);
        chk({15'h0, rdy}, 16'h0000);
        @(posedge clk);
        nvm_ok <= 1'b1;
        repeat (3) @(posedge clk);
        rdr(8'h24, 16'h0200);
        chk({15'h0, rdy}, 16'h0001);
        rdr(8'h25, 16'h01c0);
        rdr(8'h26, 16'h0100);
        rdr(8'h27, 16'he0fe);
        chk(tgt, 16'h0180);
        $display("test load done");
        @(posedge clk);
        onoff <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(8'h24 + 8'(i), gv[i], 1'b1, 1'b0);
            rdr(8'h24 + 8'(i), gv[i]);
        end
        wr(8'h28, 16'h1234, 1'b0, 1'b0);
        wr(8'h25, 16'h0300, 1'b1, 1'b0);
        wr(8'h25, 16'h0200, 1'b1, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(bc[i], bv[i], 1'b0, 1'b1);
            rdr(bc[i], kv[i]);
        end
        @(posedge clk);
        trim <= 16'hfffe;
        wr(8'h26, 16'h0001, 1'b0, 1'b1);
        @(negedge clk);
        chk(16'(cmls), 16'h0006);
        chk({15'h0, alert}, 16'h0001);
        clear();
        $display("test access done");
        @(posedge clk);
        trim <= 16'h0004;
        ramp(16'h0184, 1);
        @(posedge clk);
        msel <= 2'h2;
        ramp(16'h0204, 150);
        @(posedge clk);
        msel <= 2'h1;
        ramp(16'h0104, 300);
        @(posedge clk);
        msel <= 2'h0;
        ramp(16'h0184, 150);
        wr(8'h27, 16'he002, 1'b1, 1'b0);
        @(posedge clk);
        trim <= 16'h0000;
        ramp(16'h0180, 600);
        wr(8'h27, 16'he0fe, 1'b1, 1'b0);
        chk(16'(warns), 16'h0000);
        $display("test margin done");
        @(posedge clk);
        cmd <= 16'h0320;
        ramp(16'h0300, 460);
        chk(16'(warns), 16'h0001);
        chk({15'h0, alert}, 16'h0001);
        clear();
        @(posedge clk);
        cmd <= 16'h02c0;
        ramp(16'h02c0, 70);
        wr(8'h24, 16'h0280, 1'b1, 1'b0);
        ramp(16'h0280, 70);
        chk(16'(warns), 16'h0002);
        @(posedge clk);
        dac <= 16'h0200;
        cmd <= 16'h02a0;
        ramp(16'h0200, 150);
        chk(16'(warns), 16'h0002);
        @(posedge clk);
        conv <= 1'b0;
        dac  <= 16'hffff;
        cmd  <= 16'h0300;
        repeat (20) @(negedge clk);
        chk(16'(warns), 16'h0002);
        chk(tgt, 16'h0280);
        $display("test warning done");
        @(posedge clk);
        rst  <= 1'b1;
        psel <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({15'h0, rdy}, 16'h0000);
        repeat (2) @(negedge clk);
        chk({15'h0, rdy}, 16'h0001);
        rdr(8'h24, 16'h0180);
        rdr(8'h27, 16'he0fe);
        chk(tgt, 16'h0180);
        chk(16'(warns), 16'h0002);
        $display("test reload done");
        stop_test();
    end
endmodule
`default_nettype wire
